// [pkg/wcio_pkg.sv]
/*
 Weld-cycle discrete I/O package: timing constants, sequencer states, limit field positions.
 Assumes a 250 MHz system clock; no other surroundings.
*/
package wcio_pkg;
    localparam int CLK_HZ = 250_000_000;
    // Minimum discrete input hold time, in milliseconds
    localparam int FILT_MS = 5;
    localparam int FILT_CYC = (CLK_HZ / 1000) * FILT_MS;
    // Sonics hold-off abort time, in seconds (one minute)
    localparam int HOLDOFF_S = 60;
    localparam longint HOLDOFF_CYC = longint'(CLK_HZ) * HOLDOFF_S;
    localparam int PRESET_W = 6;
    localparam int STACK_W = 4;
    localparam int NUM_IN = 8;
    // Filtered input positions
    localparam int IN_HOLDOFF = 0;
    localparam int IN_START = 1;
    localparam int IN_TEST = 2;
    localparam int IN_LOAD = 3;
    localparam int IN_CENTER = 4;
    localparam int IN_INHIBIT = 5;
    localparam int IN_BEGIN = 6;
    localparam int IN_CLEAR = 7;
    // Limit alarm bit positions
    localparam int LIM_ENERGY = 0;
    localparam int LIM_TIME = 1;
    localparam int LIM_PEAK = 2;
    localparam int LIM_W = 3;
    typedef enum logic [3:0] {
        WCIO_IDLE,
        WCIO_DELAY,
        WCIO_WELD,
        WCIO_HOLD,
        WCIO_AB_WAIT,
        WCIO_AB_RUN,
        WCIO_TEST,
        WCIO_ABORTED
    } wcio_state_t;
endpackage : wcio_pkg

// [rtl/wcio_filter.sv]
/*
 One discrete input: two-flop synchroniser followed by a hold-time filter.
 Assumes the input is a slow level from a connector pin.
*/
`timescale 1ns/100ps
`default_nettype none
module wcio_filter #(
    parameter int HOLD_CYC = wcio_pkg::FILT_CYC
) (
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic raw_i,
    output logic level_o
);
    localparam int CW = $clog2(HOLD_CYC + 1);
    logic sync1_ff;
    logic sync2_ff;
    logic level_ff;
    logic [CW-1:0] cnt_ff;
    logic [CW-1:0] nxt_cnt;
    logic nxt_level;

    // Output changes only after the new level has stood the full hold time
    always_comb begin
        nxt_cnt = '0;
        nxt_level = level_ff;
        if (sync2_ff != level_ff) begin
            if (cnt_ff == CW'(HOLD_CYC - 1)) begin
                nxt_level = sync2_ff;
            end else begin
                nxt_cnt = cnt_ff + 1'b1;
            end
        end
    end

    // Synchroniser and filter state
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            sync1_ff <= 1'b0;
            sync2_ff <= 1'b0;
            level_ff <= 1'b0;
            cnt_ff <= '0;
        end else begin
            sync1_ff <= raw_i;
            sync2_ff <= sync1_ff;
            level_ff <= nxt_level;
            cnt_ff <= nxt_cnt;
        end
    end

    assign level_o = level_ff;
endmodule : wcio_filter
`default_nettype wire

// [rtl/wcio_top.sv]
/*
 Weld-cycle sequencer behind the discrete user I/O connector.
 Assumes an external controller drives the discrete inputs and the rest of the
 power supply supplies timing, measurement and configuration as plain ports.
*/
`timescale 1ns/100ps
`default_nettype none
module wcio_top #(
    parameter int FILT_CYC = wcio_pkg::FILT_CYC,
    parameter longint HOLDOFF_CYC = wcio_pkg::HOLDOFF_CYC,
    parameter int PRESET_W = wcio_pkg::PRESET_W,
    parameter int STACK_W = wcio_pkg::STACK_W
) (
    input wire logic mclk_i,
    input wire logic rst_i,
    // Discrete connector inputs, active high after polarity handling upstream
    input wire logic sonics_hold_off_in_i,
    input wire logic ext_weld_start_in_i,
    input wire logic test_cycle_in_i,
    input wire logic preset_load_in_i,
    input wire logic start_freq_center_in_i,
    input wire logic [PRESET_W-1:0] preset_code_in_i,
    input wire logic sonics_inhibit_in_i,
    input wire logic cycle_begin_in_i,
    input wire logic alarm_clear_in_i,
    input wire logic upper_limit_switch_i,
    // Weld engine status and configuration
    input wire logic weld_end_i,
    input wire logic weld_measured_mode_i,
    input wire logic cutoff_expired_i,
    input wire logic hold_end_i,
    input wire logic afterburst_en_i,
    input wire logic ab_delay_end_i,
    input wire logic ab_end_i,
    input wire logic amp2_active_i,
    input wire logic [STACK_W-1:0] stack_num_i,
    input wire logic stack_binary_i,
    input wire logic [wcio_pkg::LIM_W-1:0] limit_low_i,
    input wire logic [wcio_pkg::LIM_W-1:0] limit_high_i,
    input wire logic overload_i,
    input wire logic user_alarm_i,
    input wire logic [1:0] general_alarm_sel_i,
    input wire logic preset_loaded_i,
    // Outputs to the rest of the supply
    output logic sonics_on_o,
    output logic preset_load_req_o,
    output logic [PRESET_W-1:0] preset_num_o,
    output logic freq_center_req_o,
    // Connector outputs
    output logic actuator_home_out_o,
    output logic afterburst_wait_out_o,
    output logic afterburst_active_out_o,
    output logic hold_active_out_o,
    output logic hold_done_out_o,
    output logic [STACK_W-1:0] stack_select_out_o,
    output logic amplitude_step_out_o,
    output logic preset_ack_out_o,
    output logic cycle_good_out_o,
    output logic start_echo_out_o,
    output logic [wcio_pkg::LIM_W-1:0] limit_low_out_o,
    output logic [wcio_pkg::LIM_W-1:0] limit_high_out_o,
    output logic overload_out_o,
    output logic any_alarm_out_o,
    output logic user_alarm_out_o,
    output logic system_ready_out_o
);
    localparam int NI = wcio_pkg::NUM_IN;
    localparam int HW = $clog2(HOLDOFF_CYC + 1);

    logic [NI-1:0] raw_in;
    logic [NI-1:0] flt;
    logic [NI-1:0] flt_q_ff;
    logic [NI-1:0] rise;
    logic [PRESET_W-1:0] code_flt;

    // Filter every discrete input except the upper limit switch before use
    assign raw_in = {alarm_clear_in_i, cycle_begin_in_i, sonics_inhibit_in_i,
                     start_freq_center_in_i, preset_load_in_i, test_cycle_in_i,
                     ext_weld_start_in_i, sonics_hold_off_in_i};

    for (genvar g = 0; g < NI; g++) begin : g_in
        wcio_filter #(.HOLD_CYC(FILT_CYC)) u_flt (
            .mclk_i(mclk_i),
            .rst_i(rst_i),
            .raw_i(raw_in[g]),
            .level_o(flt[g])
        );
    end

    for (genvar c = 0; c < PRESET_W; c++) begin : g_code
        wcio_filter #(.HOLD_CYC(FILT_CYC)) u_flt (
            .mclk_i(mclk_i),
            .rst_i(rst_i),
            .raw_i(preset_code_in_i[c]),
            .level_o(code_flt[c])
        );
    end

    assign rise = flt & ~flt_q_ff;

    logic holdoff;
    logic inhibit;
    assign holdoff = flt[wcio_pkg::IN_HOLDOFF];
    assign inhibit = flt[wcio_pkg::IN_INHIBIT];

    // Sequencer state
    wcio_pkg::wcio_state_t state_ff;
    wcio_pkg::wcio_state_t nxt_state;
    logic [HW-1:0] hold_cnt_ff;
    logic [HW-1:0] nxt_hold_cnt;
    logic home_ff;
    logic nxt_home;
    logic hold_done_ff;
    logic nxt_hold_done;
    logic good_ff;
    logic nxt_good;
    logic cyc_alarm_ff;
    logic nxt_cyc_alarm;
    logic [wcio_pkg::LIM_W-1:0] lo_ff;
    logic [wcio_pkg::LIM_W-1:0] nxt_lo;
    logic [wcio_pkg::LIM_W-1:0] hi_ff;
    logic [wcio_pkg::LIM_W-1:0] nxt_hi;
    logic ovl_ff;
    logic nxt_ovl;
    logic usr_ff;
    logic nxt_usr;
    logic start_req;
    logic weld_done;
    logic new_alarm;

    // Start from cycle input or external start, ready-gated
    assign start_req = rise[wcio_pkg::IN_BEGIN] | rise[wcio_pkg::IN_START];
    // Inhibited measured-mode weld ends only at cutoff
    assign weld_done = (inhibit && weld_measured_mode_i) ? cutoff_expired_i : weld_end_i;
    assign new_alarm = overload_i | user_alarm_i;

    // Cycle sequencing, alarms and status next values
    always_comb begin
        nxt_state = state_ff;
        nxt_hold_cnt = '0;
        nxt_home = home_ff;
        nxt_hold_done = hold_done_ff;
        nxt_good = good_ff;
        nxt_cyc_alarm = cyc_alarm_ff | new_alarm;
        nxt_lo = lo_ff;
        nxt_hi = hi_ff;
        nxt_ovl = ovl_ff | overload_i;
        nxt_usr = usr_ff | user_alarm_i;
        if (upper_limit_switch_i) begin
            nxt_home = 1'b1;
        end else if (state_ff != wcio_pkg::WCIO_IDLE) begin
            nxt_home = 1'b0;
        end
        unique case (state_ff)
            wcio_pkg::WCIO_IDLE: begin
                if (system_ready_out_o && start_req) begin
                    nxt_state = wcio_pkg::WCIO_DELAY;
                    nxt_good = 1'b0;
                    nxt_hold_done = 1'b0;
                    nxt_cyc_alarm = new_alarm;
                    nxt_lo = '0;
                    nxt_hi = '0;
                end else if (system_ready_out_o && rise[wcio_pkg::IN_TEST]) begin
                    nxt_state = wcio_pkg::WCIO_TEST;
                end
            end
            wcio_pkg::WCIO_DELAY: begin
                // Hold-off keeps sonics off; one minute of it aborts
                if (!holdoff) begin
                    nxt_state = wcio_pkg::WCIO_WELD;
                end else if (hold_cnt_ff == HW'(HOLDOFF_CYC - 1)) begin
                    nxt_state = wcio_pkg::WCIO_ABORTED;
                    nxt_cyc_alarm = 1'b1;
                end else begin
                    nxt_hold_cnt = hold_cnt_ff + 1'b1;
                end
            end
            wcio_pkg::WCIO_WELD: begin
                if (weld_done) begin
                    nxt_state = wcio_pkg::WCIO_HOLD;
                    nxt_lo = limit_low_i;
                    nxt_hi = limit_high_i;
                    nxt_cyc_alarm = cyc_alarm_ff | new_alarm | (|limit_low_i)
                                    | (|limit_high_i);
                end
            end
            wcio_pkg::WCIO_HOLD: begin
                if (hold_end_i) begin
                    nxt_hold_done = 1'b1;
                    nxt_state = afterburst_en_i ? wcio_pkg::WCIO_AB_WAIT
                                                : wcio_pkg::WCIO_IDLE;
                    if (!afterburst_en_i) begin
                        nxt_good = ~nxt_cyc_alarm;
                    end
                end
            end
            wcio_pkg::WCIO_AB_WAIT: begin
                if (ab_delay_end_i) begin
                    nxt_state = wcio_pkg::WCIO_AB_RUN;
                end
            end
            wcio_pkg::WCIO_AB_RUN: begin
                if (ab_end_i) begin
                    nxt_state = wcio_pkg::WCIO_IDLE;
                    nxt_good = ~nxt_cyc_alarm;
                end
            end
            wcio_pkg::WCIO_TEST: begin
                if (!flt[wcio_pkg::IN_TEST]) begin
                    nxt_state = wcio_pkg::WCIO_IDLE;
                end
            end
            wcio_pkg::WCIO_ABORTED: begin
                // Every bit of flt must drop before a new cycle; preset code and limit switch are not checked
                if (flt == '0) begin
                    nxt_state = wcio_pkg::WCIO_IDLE;
                end
            end
            default: nxt_state = wcio_pkg::WCIO_IDLE;
        endcase
        // Alarm clear drops latched alarms; a new event wins
        if (rise[wcio_pkg::IN_CLEAR]) begin
            nxt_ovl = overload_i;
            nxt_usr = user_alarm_i;
            nxt_lo = (state_ff == wcio_pkg::WCIO_WELD && weld_done) ? limit_low_i : '0;
            nxt_hi = (state_ff == wcio_pkg::WCIO_WELD && weld_done) ? limit_high_i : '0;
        end
    end

    // Preset and frequency centering
    logic [PRESET_W-1:0] pnum_ff;
    logic [PRESET_W-1:0] nxt_pnum;
    logic pend_ff;
    logic nxt_pend;
    logic ack_ff;
    logic nxt_ack;

    always_comb begin
        nxt_pnum = pnum_ff;
        nxt_pend = pend_ff;
        nxt_ack = ack_ff;
        if (rise[wcio_pkg::IN_LOAD]) begin
            nxt_pnum = code_flt;
            nxt_pend = 1'b1;
            nxt_ack = 1'b0;
        end else if (pend_ff && preset_loaded_i) begin
            nxt_pend = 1'b0;
            nxt_ack = 1'b1;
        end
    end

    // Stack select in one-hot or binary form
    logic [STACK_W-1:0] sel_ff;
    logic [STACK_W-1:0] nxt_sel;
    always_comb begin
        nxt_sel = stack_num_i;
        if (!stack_binary_i) begin
            nxt_sel = '0;
            for (int i = 0; i < STACK_W; i++) begin
                if (stack_num_i == STACK_W'(i)) begin
                    nxt_sel[i] = 1'b1;
                end
            end
        end
    end

    // General alarm selection
    logic gen_ff;
    logic nxt_gen;
    always_comb begin
        unique case (general_alarm_sel_i)
            2'h0: nxt_gen = nxt_ovl | nxt_usr | (|nxt_lo) | (|nxt_hi);
            2'h1: nxt_gen = nxt_ovl;
            2'h2: nxt_gen = (|nxt_lo) | (|nxt_hi);
            default: nxt_gen = nxt_usr;
        endcase
    end

    // Register all state
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            flt_q_ff <= '0;
            state_ff <= wcio_pkg::WCIO_IDLE;
            hold_cnt_ff <= '0;
            home_ff <= 1'b0;
            hold_done_ff <= 1'b0;
            good_ff <= 1'b0;
            cyc_alarm_ff <= 1'b0;
            lo_ff <= '0;
            hi_ff <= '0;
            ovl_ff <= 1'b0;
            usr_ff <= 1'b0;
            pnum_ff <= '0;
            pend_ff <= 1'b0;
            ack_ff <= 1'b0;
            sel_ff <= '0;
            gen_ff <= 1'b0;
        end else begin
            flt_q_ff <= flt;
            state_ff <= nxt_state;
            hold_cnt_ff <= nxt_hold_cnt;
            home_ff <= nxt_home;
            hold_done_ff <= nxt_hold_done;
            good_ff <= nxt_good;
            cyc_alarm_ff <= nxt_cyc_alarm;
            lo_ff <= nxt_lo;
            hi_ff <= nxt_hi;
            ovl_ff <= nxt_ovl;
            usr_ff <= nxt_usr;
            pnum_ff <= nxt_pnum;
            pend_ff <= nxt_pend;
            ack_ff <= nxt_ack;
            sel_ff <= nxt_sel;
            gen_ff <= nxt_gen;
        end
    end

    // Sonics on in weld only, never under hold-off or inhibit
    assign sonics_on_o = (state_ff == wcio_pkg::WCIO_WELD) && !holdoff && !inhibit;
    assign preset_load_req_o = pend_ff;
    assign preset_num_o = pnum_ff;
    assign freq_center_req_o = rise[wcio_pkg::IN_CENTER];
    // State indicators
    assign afterburst_wait_out_o = (state_ff == wcio_pkg::WCIO_AB_WAIT);
    assign afterburst_active_out_o = (state_ff == wcio_pkg::WCIO_AB_RUN);
    assign hold_active_out_o = (state_ff == wcio_pkg::WCIO_HOLD);
    assign hold_done_out_o = hold_done_ff;
    assign actuator_home_out_o = home_ff;
    assign stack_select_out_o = sel_ff;
    assign amplitude_step_out_o = amp2_active_i;
    assign preset_ack_out_o = ack_ff;
    assign cycle_good_out_o = good_ff;
    // Echo through delay, weld and hold
    assign start_echo_out_o = (state_ff == wcio_pkg::WCIO_DELAY)
                              || (state_ff == wcio_pkg::WCIO_WELD)
                              || (state_ff == wcio_pkg::WCIO_HOLD);
    assign limit_low_out_o = lo_ff;
    assign limit_high_out_o = hi_ff;
    assign overload_out_o = ovl_ff;
    assign user_alarm_out_o = usr_ff;
    assign any_alarm_out_o = gen_ff;
    // Ready only idle with no latched reset-required alarm
    assign system_ready_out_o = (state_ff == wcio_pkg::WCIO_IDLE) && !ovl_ff
                                && !(|lo_ff) && !(|hi_ff);
endmodule : wcio_top
`default_nettype wire

// [verification/wcio_checker.sv]
/*
 Port-level timing checks for the weld-cycle I/O block.
 Assumes it is bound into wcio_top and sees only that module's ports.
*/
`timescale 1ns/100ps
`default_nettype none
module wcio_checker #(
    parameter int STACK_W = 4
) (
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic upper_limit_switch_i,
    input wire logic amp2_active_i,
    input wire logic [STACK_W-1:0] stack_num_i,
    input wire logic stack_binary_i,
    input wire logic overload_i,
    input wire logic sonics_on_o,
    input wire logic freq_center_req_o,
    input wire logic actuator_home_out_o,
    input wire logic afterburst_wait_out_o,
    input wire logic afterburst_active_out_o,
    input wire logic hold_active_out_o,
    input wire logic hold_done_out_o,
    input wire logic [STACK_W-1:0] stack_select_out_o,
    input wire logic amplitude_step_out_o,
    input wire logic cycle_good_out_o,
    input wire logic start_echo_out_o,
    input wire logic [wcio_pkg::LIM_W-1:0] limit_high_out_o,
    input wire logic overload_out_o,
    input wire logic system_ready_out_o
);
    default clocking @(posedge mclk_i); endclocking
    default disable iff (rst_i);
    // Sequencer has just left the hold phase
    sequence hold_exit;
        hold_active_out_o ##1 !hold_active_out_o;
    endsequence
    // Ready and state outputs against each other
    ready_idle_a: assert property (system_ready_out_o |->
        !(start_echo_out_o || hold_active_out_o)) else $error("ready while cycling");
    ready_alarm_a: assert property ((overload_out_o || |limit_high_out_o) |->
        !system_ready_out_o) else $error("ready with alarm pending");
    state_excl_a: assert property ($onehot0({afterburst_wait_out_o,
        afterburst_active_out_o, hold_active_out_o})) else $error("two state outputs at once");
    sonics_gate_a: assert property (sonics_on_o |->
        start_echo_out_o && !hold_active_out_o) else $error("sonics outside weld");
    good_drop_a: assert property ($rose(start_echo_out_o) |-> !cycle_good_out_o)
        else $error("cycle okay kept at start");
    hold_done_a: assert property (hold_exit |-> ##[0:1] hold_done_out_o)
        else $error("end of hold missing");
    // Pin-level follow relations
    amp_follow_a: assert property (amplitude_step_out_o == amp2_active_i)
        else $error("amplitude step wrong");
    home_set_a: assert property ($rose(upper_limit_switch_i) |->
        ##[1:2] actuator_home_out_o) else $error("home not shown");
    stack_bin_a: assert property (stack_binary_i |=>
        stack_select_out_o == $past(stack_num_i)) else $error("stack code wrong");
    center_pulse_a: assert property (freq_center_req_o |=> !freq_center_req_o)
        else $error("centre request too long");
    ovl_latch_a: assert property (overload_i |=> overload_out_o)
        else $error("overload not latched");
endmodule : wcio_checker
`default_nettype wire

// [verification/wcio_ctrl_model.sv]
/*
 Controller model: drives the discrete connector inputs as a PLC would.
 Assumes the testbench calls its tasks and ready_i is the device ready pin.
*/
`timescale 1ns/100ps
`default_nettype none
module wcio_ctrl_model #(
    parameter int FILT_CYC = 4
) (
    input wire logic mclk_i,
    input wire logic ready_i,
    output logic [wcio_pkg::NUM_IN-1:0] lvl_o,
    output logic [wcio_pkg::PRESET_W-1:0] code_o
);
    // Active-high drive: a lost supply reads as idle, never as start
    initial begin
        lvl_o = '0;
        code_o = '0;
    end
    // Keep a new level past the device filter window
    task automatic hold_lvl;
        repeat (FILT_CYC + 6) @(posedge mclk_i);
        #1;
    endtask : hold_lvl
    // Change one input and keep it; test stays up until dropped here
    task automatic set_in(input int idx, input logic v);
        @(posedge mclk_i);
        #1 lvl_o[idx] = v;
        hold_lvl();
    endtask : set_in
    // Change the recall code and keep it
    task automatic set_code(input logic [wcio_pkg::PRESET_W-1:0] v);
        @(posedge mclk_i);
        #1 code_o = v;
        hold_lvl();
    endtask : set_code
    // Start a weld only from the ready state
    task automatic go;
        if (ready_i === 1'h1) begin
            @(posedge mclk_i);
            #1 lvl_o[wcio_pkg::IN_START] = 1'h1;
            lvl_o[wcio_pkg::IN_BEGIN] = 1'h1;
            hold_lvl();
        end
    endtask : go
endmodule : wcio_ctrl_model
`default_nettype wire

// [verification/wcio_top_tb_top.sv]
/*
 Directed self-checking testbench for the weld-cycle I/O block.
 Assumes the controller model and the bound port checker.
*/
`timescale 1ns/100ps
`default_nettype none
module wcio_top_tb_top;
    localparam int FLT = 4;
    localparam longint HOF = 50;
    logic mclk_i = 1'h0;
    logic rst_i = 1'h1;
    logic weld_end_i = 1'h0, weld_measured_mode_i = 1'h0, cutoff_expired_i = 1'h0;
    logic hold_end_i = 1'h0, afterburst_en_i = 1'h0, ab_delay_end_i = 1'h0, ab_end_i = 1'h0;
    logic amp2_active_i = 1'h0, stack_binary_i = 1'h0, overload_i = 1'h0, user_alarm_i = 1'h0;
    logic preset_loaded_i = 1'h0, upper_limit_switch_i = 1'h0;
    logic [3:0] stack_num_i = 4'h0, stack_select_out_o;
    logic [2:0] limit_low_i = 3'h0, limit_high_i = 3'h0, limit_low_out_o, limit_high_out_o;
    logic [1:0] general_alarm_sel_i = 2'h0;
    logic [7:0] lvl;
    logic [5:0] code, preset_num_o;
    logic sonics_on_o, preset_load_req_o, freq_center_req_o, actuator_home_out_o;
    logic afterburst_wait_out_o, afterburst_active_out_o, hold_active_out_o, hold_done_out_o;
    logic amplitude_step_out_o, preset_ack_out_o, cycle_good_out_o, start_echo_out_o;
    logic overload_out_o, any_alarm_out_o, user_alarm_out_o, system_ready_out_o;
    int n_fail = 0, checks_done = 0, n_ctr = 0;
    // Clock at 250 MHz
    always #2 mclk_i = ~mclk_i;
    // Count cycles with the centring request up
    always @(posedge mclk_i) if (freq_center_req_o === 1'h1) n_ctr <= n_ctr + 1;
    // Controller on the far side and the block itself
    wcio_ctrl_model #(.FILT_CYC(FLT)) ctl (.mclk_i, .ready_i(system_ready_out_o),
        .lvl_o(lvl), .code_o(code));
    wcio_top #(.FILT_CYC(FLT), .HOLDOFF_CYC(HOF)) DUT (.mclk_i, .rst_i,
        .sonics_hold_off_in_i(lvl[wcio_pkg::IN_HOLDOFF]), .upper_limit_switch_i, .weld_end_i,
        .test_cycle_in_i(lvl[wcio_pkg::IN_TEST]), .preset_load_in_i(lvl[wcio_pkg::IN_LOAD]),
        .start_freq_center_in_i(lvl[wcio_pkg::IN_CENTER]), .preset_code_in_i(code),
        .sonics_inhibit_in_i(lvl[wcio_pkg::IN_INHIBIT]), .cycle_begin_in_i(lvl[wcio_pkg::IN_BEGIN]),
        .ext_weld_start_in_i(lvl[wcio_pkg::IN_START]), .alarm_clear_in_i(lvl[wcio_pkg::IN_CLEAR]),
        .weld_measured_mode_i, .cutoff_expired_i, .hold_end_i, .afterburst_en_i, .ab_delay_end_i,
        .ab_end_i, .amp2_active_i, .stack_num_i, .stack_binary_i, .limit_low_i, .limit_high_i,
        .overload_i, .user_alarm_i, .general_alarm_sel_i, .preset_loaded_i, .sonics_on_o,
        .preset_load_req_o, .preset_num_o, .freq_center_req_o, .actuator_home_out_o,
        .afterburst_wait_out_o, .afterburst_active_out_o, .hold_active_out_o, .hold_done_out_o,
        .stack_select_out_o, .amplitude_step_out_o, .preset_ack_out_o, .cycle_good_out_o,
        .start_echo_out_o, .limit_low_out_o, .limit_high_out_o, .overload_out_o,
        .any_alarm_out_o, .user_alarm_out_o, .system_ready_out_o);
    // Compare one value and count
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_fail++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    // One-cycle pulse on a status input, then let it settle
    task automatic pulse(ref logic s);
        @(posedge mclk_i);
        #1 s = 1'h1;
        @(posedge mclk_i);
        #1 s = 1'h0;
        repeat (2) @(posedge mclk_i);
        #1;
    endtask : pulse
    // Raise and drop the alarm clear input
    task automatic t_clear;
        ctl.set_in(wcio_pkg::IN_CLEAR, 1'h1);
        ctl.set_in(wcio_pkg::IN_CLEAR, 1'h0);
    endtask : t_clear
    // Full weld cycle, optionally with afterburst, inhibit and limit alarms
    task automatic t_cycle(input bit ab, input bit inh, input logic [2:0] lo, hi);
        afterburst_en_i = ab;
        weld_measured_mode_i = inh;
        ctl.set_in(wcio_pkg::IN_HOLDOFF, 1'h1);
        ctl.go();
        chk({start_echo_out_o, cycle_good_out_o, sonics_on_o}, 8'h04);
        if (inh) ctl.set_in(wcio_pkg::IN_INHIBIT, 1'h1);
        ctl.set_in(wcio_pkg::IN_HOLDOFF, 1'h0);
        chk(sonics_on_o, {7'h00, !inh});
        limit_low_i = lo;
        limit_high_i = hi;
        pulse(weld_end_i);
        limit_low_i = 3'h0;
        limit_high_i = 3'h0;
        if (inh) begin
            chk(hold_active_out_o, 8'h00);
            pulse(cutoff_expired_i);
        end
        chk({start_echo_out_o, hold_active_out_o, system_ready_out_o}, 8'h06);
        pulse(hold_end_i);
        if (ab) begin
            chk({afterburst_wait_out_o, hold_active_out_o}, 8'h02);
            pulse(ab_delay_end_i);
            chk({afterburst_active_out_o, afterburst_wait_out_o}, 8'h02);
            pulse(ab_end_i);
        end
        chk({hold_done_out_o, cycle_good_out_o}, {6'h00, 1'h1, lo == 0 && hi == 0});
        chk({limit_low_out_o, limit_high_out_o}, {2'h0, lo, hi});
        ctl.set_in(wcio_pkg::IN_START, 1'h0);
        ctl.set_in(wcio_pkg::IN_BEGIN, 1'h0);
        ctl.set_in(wcio_pkg::IN_INHIBIT, 1'h0);
        chk(system_ready_out_o, {7'h00, lo == 0 && hi == 0});
    endtask : t_cycle
    // Overload and custom alarms, every general alarm selection, then clear
    task automatic t_alarm;
        pulse(overload_i);
        pulse(user_alarm_i);
        chk({overload_out_o, user_alarm_out_o, system_ready_out_o}, 8'h06);
        for (int s = 0; s < 4; s++) begin
            general_alarm_sel_i = s[1:0];
            repeat (2) @(posedge mclk_i);
            #1 chk(any_alarm_out_o, {7'h00, s != 2});
        end
        t_clear();
        chk({overload_out_o, user_alarm_out_o, system_ready_out_o}, 8'h01);
    endtask : t_alarm
    // Test cycle blocks ready while held
    task automatic t_test;
        ctl.set_in(wcio_pkg::IN_TEST, 1'h1);
        chk({system_ready_out_o, start_echo_out_o}, 8'h00);
        ctl.set_in(wcio_pkg::IN_TEST, 1'h0);
        chk(system_ready_out_o, 8'h01);
    endtask : t_test
    // Two preset loads covering every code bit
    task automatic t_preset;
        for (int i = 0; i < 2; i++) begin
            ctl.set_code(i ? 6'h15 : 6'h2A);
            ctl.set_in(wcio_pkg::IN_LOAD, 1'h1);
            chk({preset_load_req_o, preset_ack_out_o, preset_num_o},
                {2'h2, i ? 6'h15 : 6'h2A});
            pulse(preset_loaded_i);
            chk({preset_load_req_o, preset_ack_out_o}, 8'h01);
            ctl.set_in(wcio_pkg::IN_LOAD, 1'h0);
        end
    endtask : t_preset
    // One centring request per rise
    task automatic t_center;
        int n0 = n_ctr;
        ctl.set_in(wcio_pkg::IN_CENTER, 1'h1);
        ctl.set_in(wcio_pkg::IN_CENTER, 1'h0);
        chk(n_ctr - n0, 8'h01);
    endtask : t_center
    // Stack codes, amplitude step and actuator home
    task automatic t_pins;
        for (int i = 0; i < 20; i++) begin
            stack_binary_i = (i < 16);
            stack_num_i = i[3:0];
            amp2_active_i = i[0];
            repeat (2) @(posedge mclk_i);
            #1 chk({amplitude_step_out_o, 3'h0, stack_select_out_o},
                   {i[0], 3'h0, (i < 16) ? i[3:0] : 4'h1 << i[1:0]});
        end
        upper_limit_switch_i = 1'h1;
        repeat (3) @(posedge mclk_i);
        #1 chk(actuator_home_out_o, 8'h01);
    endtask : t_pins
    // Hold-off kept past the limit aborts until hold-off and both start inputs drop
    task automatic t_abort;
        ctl.set_in(wcio_pkg::IN_HOLDOFF, 1'h1);
        ctl.go();
        repeat (HOF + 10) @(posedge mclk_i);
        #1 chk({system_ready_out_o, sonics_on_o}, 8'h00);
        ctl.set_in(wcio_pkg::IN_HOLDOFF, 1'h0);
        chk({system_ready_out_o, sonics_on_o}, 8'h00);
        ctl.set_in(wcio_pkg::IN_START, 1'h0);
        ctl.set_in(wcio_pkg::IN_BEGIN, 1'h0);
        chk(system_ready_out_o, 8'h01);
    endtask : t_abort
    // Print counts and verdict, end the run
    task automatic stop_test;
        $display("checks_done=%0d n_fail=%0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : stop_test
    // Main sequence
    initial begin
        repeat (2) @(posedge mclk_i);
        #1 rst_i = 1'h0;
        chk({system_ready_out_o, start_echo_out_o, hold_done_out_o}, 8'h04);
        t_cycle(1'h0, 1'h0, 3'h0, 3'h0);
        t_cycle(1'h1, 1'h1, 3'h0, 3'h0);
        t_cycle(1'h0, 1'h0, 3'h4, 3'h2);
        t_clear();
        chk({limit_low_out_o, limit_high_out_o, system_ready_out_o}, 8'h01);
        t_alarm();
        t_test();
        t_preset();
        t_center();
        t_pins();
        t_abort();
        stop_test();
    end
    // Watchdog against a hang
    initial begin
        repeat (5000) @(posedge mclk_i);
        n_fail++;
        stop_test();
    end
endmodule : wcio_top_tb_top
bind wcio_top wcio_checker #(.STACK_W(STACK_W)) u_chk (.mclk_i, .rst_i, .upper_limit_switch_i,
    .amp2_active_i, .stack_num_i, .stack_binary_i, .overload_i, .sonics_on_o, .freq_center_req_o,
    .actuator_home_out_o, .afterburst_wait_out_o, .afterburst_active_out_o, .hold_active_out_o,
    .hold_done_out_o, .stack_select_out_o, .amplitude_step_out_o, .cycle_good_out_o,
    .start_echo_out_o, .limit_high_out_o, .overload_out_o, .system_ready_out_o);
`default_nettype wire
